// ---- core/tws_host.sv ----
`timescale 1ns/100ps
module tws_host (
  input  wire logic       sys_clk,    // System clock
  input  wire logic       reset_n,    // Synchronous reset
  tws_if.host             pins,       // Bus lines
  input  wire logic       go,         // Start a read transfer
  input  wire logic [6:0] slave_addr, // Target address
  input  wire logic [7:0] byte_count, // Bytes to read
  output logic      [7:0] rx_data,    // Last byte read
  output logic            rx_valid,   // rx_data new
  output logic            done,       // Transfer finished
  output logic            addr_nack,  // Address not acknowledged
  output logic            busy        // Transfer running
);

  typedef struct packed {
    tws_pkg::tws_mst_state_t state;
    logic [2:0]              scl_sync;
    logic [2:0]              sda_sync;
    logic                    scl_v;
    logic                    sda_v;
    logic [7:0]              tick_cnt;
    logic [1:0]              phase;
    logic [3:0]              bit_cnt;
    logic                    is_addr;
    logic [7:0]              shift;
    logic [7:0]              left;
    logic                    scl_oe;
    logic                    sda_oe;
    logic [7:0]              rx_data;
    logic                    rx_valid;
    logic                    done;
    logic                    nack;
    logic                    busy;
  } tws_mst_q_t;

  tws_mst_q_t q;
  tws_mst_q_t d;
  logic       tick;
  logic       scl_new;
  logic       sda_new;

  assign tick    = q.tick_cnt == tws_pkg::TICK_LAST;
  assign scl_new = (q.scl_sync[1] == q.scl_sync[2]) ? q.scl_sync[2] : q.scl_v;
  assign sda_new = (q.sda_sync[1] == q.sda_sync[2]) ? q.sda_sync[2] : q.sda_v;

  always_comb begin
    d          = q;
    d.scl_sync = {q.scl_sync[1:0], pins.scl};
    d.sda_sync = {q.sda_sync[1:0], pins.sda};
    d.scl_v    = scl_new;
    d.sda_v    = sda_new;
    d.tick_cnt = tick ? 8'h00 : q.tick_cnt + 8'h01;
    d.rx_valid = 1'b0;
    d.done     = 1'b0;
    case (q.state)
      tws_pkg::M_IDLE: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (go) begin
          d.shift    = {slave_addr, 1'b1};
          d.left     = byte_count;
          d.is_addr  = 1'b1;
          d.nack     = 1'b0;
          d.busy     = 1'b1;
          d.phase    = 2'h0;
          d.tick_cnt = 8'h00;
          d.state    = tws_pkg::M_START;
        end
      end
      tws_pkg::M_START: begin
        if (tick) begin
          if (q.phase == 2'h0) begin
            d.sda_oe = 1'b1;
            d.phase  = 2'h1;
          end else begin
            d.scl_oe  = 1'b1;
            d.phase   = 2'h0;
            d.bit_cnt = 4'h0;
            d.state   = tws_pkg::M_XFER;
          end
        end
      end
      tws_pkg::M_XFER: begin
        if (tick) begin
          case (q.phase)
            2'h0: begin
              if (q.bit_cnt != tws_pkg::ACK_SLOT) begin
                d.sda_oe = q.is_addr ? ~q.shift[7] : 1'b0;
              end else begin
                d.sda_oe = ~q.is_addr & (q.left != 8'h01);
              end
              d.phase = 2'h1;
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              // Waits here while the slave stretches the clock
              if (q.scl_v) begin
                d.phase = 2'h2;
              end
            end
            2'h2: begin
              if (q.bit_cnt != tws_pkg::ACK_SLOT) begin
                d.shift = {q.shift[6:0], q.sda_v};
              end else if (q.is_addr) begin
                d.nack = q.sda_v;
              end else begin
                d.rx_data  = q.shift;
                d.rx_valid = 1'b1;
              end
              d.phase = 2'h3;
            end
            default: begin
              d.scl_oe = 1'b1;
              d.phase  = 2'h0;
              if (q.bit_cnt == tws_pkg::ACK_SLOT) begin
                d.bit_cnt = 4'h0;
                if (q.is_addr) begin
                  d.is_addr = 1'b0;
                  if (q.nack || q.left == 8'h00) begin
                    d.state = tws_pkg::M_STOP;
                  end
                end else begin
                  d.left = q.left - 8'h01;
                  if (q.left == 8'h01) begin
                    d.state = tws_pkg::M_STOP;
                  end
                end
              end else begin
                d.bit_cnt = q.bit_cnt + 4'h1;
              end
            end
          endcase
        end
      end
      default: begin
        if (tick) begin
          if (q.phase == 2'h0) begin
            d.sda_oe = 1'b1;
            d.phase  = 2'h1;
          end else if (q.phase == 2'h1) begin
            d.scl_oe = 1'b0;
            if (q.scl_v) begin
              d.phase = 2'h2;
            end
          end else begin
            d.sda_oe = 1'b0;
            d.done   = 1'b1;
            d.busy   = 1'b0;
            d.phase  = 2'h0;
            d.state  = tws_pkg::M_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.scl_oe_host  = q.scl_oe;
  assign pins.sda_oe_host  = q.sda_oe;
  assign pins.scl_out_host = 1'b0;
  assign pins.sda_out_host = 1'b0;
  assign rx_data           = q.rx_data;
  assign rx_valid          = q.rx_valid;
  assign done              = q.done;
  assign addr_nack         = q.nack;
  assign busy              = q.busy;

endmodule // tws_host

// ---- core/tws_if.sv ----
`timescale 1ns/100ps
interface tws_if;
  logic scl_oe_dev;
  logic sda_oe_dev;
  logic scl_out_dev;
  logic sda_out_dev;
  logic scl_oe_host;
  logic sda_oe_host;
  logic scl_out_host;
  logic sda_out_host;
  logic scl;
  logic sda;

  // Open-drain lines with pull-up: low while any end drives
  assign scl = ~(scl_oe_dev | scl_oe_host);
  assign sda = ~(sda_oe_dev | sda_oe_host);

  modport dev (
    input  scl,
    input  sda,
    output scl_oe_dev,
    output sda_oe_dev,
    output scl_out_dev,
    output sda_out_dev
  );

  modport host (
    input  scl,
    input  sda,
    output scl_oe_host,
    output sda_oe_host,
    output scl_out_host,
    output sda_out_host
  );
endinterface // tws_if

// ---- core/tws_pkg.sv ----
package tws_pkg;

  // Bus state codes reported through the status register
  localparam logic [7:0] CODE_OWN_READ  = 8'hA8;
  localparam logic [7:0] CODE_ARB_READ  = 8'hB0;
  localparam logic [7:0] CODE_DATA_ACK  = 8'hB8;
  localparam logic [7:0] CODE_DATA_NACK = 8'hC0;
  localparam logic [7:0] CODE_LAST_ACK  = 8'hC8;
  localparam logic [7:0] CODE_NONE      = 8'hF8;
  localparam logic [7:0] CODE_BUS_ERR   = 8'h00;
  localparam logic [7:0] CODE_OWN_WRITE = 8'h60;
  localparam logic [7:0] CODE_GC_WRITE  = 8'h70;

  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

  // Software register selects
  localparam logic [1:0] SEL_OWN_ADDR = 2'h0;
  localparam logic [1:0] SEL_CONTROL  = 2'h1;
  localparam logic [1:0] SEL_DATA     = 2'h2;
  localparam logic [1:0] SEL_STATUS   = 2'h3;

  // Control register fields and the own-address general call enable bit
  localparam int CTL_FLAG   = 7;
  localparam int CTL_ACK_EN = 6;
  localparam int CTL_START  = 5;
  localparam int CTL_STOP   = 4;
  localparam int CTL_WCOL   = 3;
  localparam int CTL_EN     = 2;
  localparam int CTL_IE     = 0;
  localparam int OWN_GCE    = 0;

  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST     = 8'hFF;
  localparam logic [1:0] PRESC_RST    = 2'h0;

  // Bit counter marks
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT  = 4'h8;

  // Host bit timing: one quarter of a bus bit period
  localparam int         SYS_CLK_NS  = 10;
  localparam int         QUARTER_NS  = 2500;
  localparam int         QUARTER_CYC = QUARTER_NS / SYS_CLK_NS;
  localparam logic [7:0] TICK_LAST   = 8'(QUARTER_CYC - 1);

  typedef enum logic [2:0] {
    S_IDLE     = 3'h0,
    S_ADDR     = 3'h1,
    S_ADDR_ACK = 3'h3,
    S_HOLD     = 3'h2,
    S_TX       = 3'h6,
    S_TX_ACK   = 3'h7,
    S_IGNORE   = 3'h5
  } tws_slv_state_t;

  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_START = 2'h1,
    M_XFER  = 2'h3,
    M_STOP  = 2'h2
  } tws_mst_state_t;

endpackage

// ---- core/tws_slave.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Match address against upper seven own-address bits
// - General call answered only when enabled
// - Software enables, acks, clears start/stop first
// - Read bit enters send, write bit receive (code only reports 60/70 and then ignores the data bytes)
// - Own address read acknowledged gives code A8
// - Lost arbitration then addressed gives code B0
// - Acknowledged data byte gives code B8
// - Acknowledge enable chooses normal or final byte
// - Not-acknowledge after byte gives code C0
// - Acknowledge after final byte gives code C8
// - Clearing flag after C0/C8 leaves addressed mode (code leaves it when it sets C0/C8)
// - After final byte ignore master, read ones
// - Acknowledge enable low isolates but keeps monitoring
// - Sleep still recognises address and wakes part
// - Hold clock low until flag cleared (code holds it only after A8, B0 and B8)
// - Data register not refreshed from bus
// - Status codes assume prescaler bits zero
// - Flag clear means status reads F8
// - Misplaced START or STOP gives code 00
module tws_slave (
  input  wire logic       sys_clk,      // System clock
  input  wire logic       reset_n,      // Synchronous reset
  tws_if.dev              pins,         // Bus lines
  input  wire logic       reg_wr,       // Register write strobe
  input  wire logic [1:0] reg_sel,      // Register select
  input  wire logic [7:0] reg_wdata,    // Register write data
  input  wire logic       arb_lost,     // Master logic lost arbitration
  input  wire logic       sleep_mode,   // Part in a deep sleep state
  output logic      [7:0] rd_own_addr,  // own_slave_address
  output logic      [7:0] rd_control,   // interface_control
  output logic      [7:0] rd_data,      // shift_data_register
  output logic      [7:0] rd_status,    // bus_state_code
  output logic            irq,          // Flag and interrupt enable
  output logic            wake          // Wake request
);

  typedef struct packed {
    tws_pkg::tws_slv_state_t state;
    logic [2:0]              scl_sync;
    logic [2:0]              sda_sync;
    logic                    scl_v;
    logic                    sda_v;
    logic [7:0]              shift;
    logic [3:0]              bit_cnt;
    logic                    acked;
    logic                    last;
    logic [7:0]              own_addr;
    logic [7:0]              data;
    logic                    flag;
    logic                    ack_en;
    logic                    start_req;
    logic                    stop_req;
    logic                    wcol;
    logic                    enable;
    logic                    int_en;
    logic [1:0]              presc;
    logic [7:0]              code;
    logic [7:0]              status;
    logic                    sda_oe;
    logic                    scl_oe;
    logic                    irq;
    logic                    wake;
  } tws_slv_q_t;

  tws_slv_q_t q;
  tws_slv_q_t d;
  logic       scl_new;
  logic       sda_new;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       own_hit;
  logic       gc_hit;
  logic       flag_clear;

  assign scl_new   = (q.scl_sync[1] == q.scl_sync[2]) ? q.scl_sync[2] : q.scl_v;
  assign sda_new   = (q.sda_sync[1] == q.sda_sync[2]) ? q.sda_sync[2] : q.sda_v;
  assign scl_rise  = ~q.scl_v & scl_new;
  assign scl_fall  = q.scl_v & ~scl_new;
  assign bus_start = q.scl_v & scl_new & q.sda_v & ~sda_new;
  assign bus_stop  = q.scl_v & scl_new & ~q.sda_v & sda_new;
  assign own_hit   = q.shift[7:1] == q.own_addr[7:1];
  assign gc_hit    = q.own_addr[tws_pkg::OWN_GCE] & ~q.shift[0]
                   & (q.shift[7:1] == tws_pkg::GENERAL_CALL_ADDR);
  assign flag_clear = reg_wr & (reg_sel == tws_pkg::SEL_CONTROL)
                    & reg_wdata[tws_pkg::CTL_FLAG] & q.flag;

  always_comb begin
    d          = q;
    d.scl_sync = {q.scl_sync[1:0], pins.scl};
    d.sda_sync = {q.sda_sync[1:0], pins.sda};
    d.scl_v    = scl_new;
    d.sda_v    = sda_new;

    // Software side; hardware sets below override a same-cycle clear
    if (reg_wr) begin
      if (reg_sel == tws_pkg::SEL_OWN_ADDR) begin
        d.own_addr = reg_wdata;
      end else if (reg_sel == tws_pkg::SEL_CONTROL) begin
        if (reg_wdata[tws_pkg::CTL_FLAG]) begin
          d.flag = 1'b0;
        end
        d.ack_en    = reg_wdata[tws_pkg::CTL_ACK_EN];
        d.start_req = reg_wdata[tws_pkg::CTL_START];
        d.stop_req  = reg_wdata[tws_pkg::CTL_STOP];
        d.enable    = reg_wdata[tws_pkg::CTL_EN];
        d.int_en    = reg_wdata[tws_pkg::CTL_IE];
      end else if (reg_sel == tws_pkg::SEL_DATA) begin
        if (q.flag) begin
          d.data = reg_wdata;
          d.wcol = 1'b0;
        end else begin
          d.wcol = 1'b1;
        end
      end else begin
        d.presc = reg_wdata[1:0];
      end
    end

    // Bus error recovery leaves the stop request cleared
    if (flag_clear && q.code == tws_pkg::CODE_BUS_ERR) begin
      d.stop_req = 1'b0;
    end

    case (q.state)
      tws_pkg::S_IDLE, tws_pkg::S_IGNORE: begin
        d.sda_oe = 1'b0;
        d.scl_oe = 1'b0;
        if (bus_start) begin
          d.bit_cnt = 4'h0;
          d.state   = tws_pkg::S_ADDR;
        end else if (bus_stop) begin
          d.state = tws_pkg::S_IDLE;
        end
      end
      tws_pkg::S_ADDR: begin
        if ((bus_start || bus_stop) && q.bit_cnt != 4'h0) begin
          d.flag  = 1'b1;
          d.code  = tws_pkg::CODE_BUS_ERR;
          d.state = tws_pkg::S_IDLE;
        end else if (bus_start) begin
          d.bit_cnt = 4'h0;
        end else if (bus_stop) begin
          d.state = tws_pkg::S_IDLE;
        end else if (scl_rise) begin
          d.shift   = {q.shift[6:0], sda_new};
          d.bit_cnt = q.bit_cnt + 4'h1;
        end else if (scl_fall && q.bit_cnt == tws_pkg::ACK_SLOT) begin
          // Not answering with ack_en low still keeps the bus watched
          if (q.ack_en && (own_hit || gc_hit)) begin
            d.sda_oe = 1'b1;
            d.state  = tws_pkg::S_ADDR_ACK;
          end else begin
            d.state = tws_pkg::S_IGNORE;
          end
        end
      end
      tws_pkg::S_ADDR_ACK: begin
        if (bus_start || bus_stop) begin
          d.sda_oe = 1'b0;
          d.flag   = 1'b1;
          d.code   = tws_pkg::CODE_BUS_ERR;
          d.state  = tws_pkg::S_IDLE;
        end else if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.flag   = 1'b1;
          d.wake   = sleep_mode;
          if (q.shift[0]) begin
            d.code   = arb_lost ? tws_pkg::CODE_ARB_READ : tws_pkg::CODE_OWN_READ;
            d.scl_oe = 1'b1;
            d.state  = tws_pkg::S_HOLD;
          end else begin
            // Receive direction is reported only; data bytes are not taken
            d.code  = gc_hit ? tws_pkg::CODE_GC_WRITE : tws_pkg::CODE_OWN_WRITE;
            d.state = tws_pkg::S_IGNORE;
          end
        end
      end
      tws_pkg::S_HOLD: begin
        d.scl_oe = 1'b1;
        if (flag_clear) begin
          d.shift   = q.data;
          d.last    = ~d.ack_en;
          d.bit_cnt = 4'h0;
          d.sda_oe  = ~q.data[7];
          d.scl_oe  = 1'b0;
          d.state   = tws_pkg::S_TX;
        end
      end
      tws_pkg::S_TX: begin
        if (bus_start || bus_stop) begin
          d.sda_oe = 1'b0;
          d.flag   = 1'b1;
          d.code   = tws_pkg::CODE_BUS_ERR;
          d.state  = tws_pkg::S_IDLE;
        end else if (scl_fall) begin
          if (q.bit_cnt == tws_pkg::BITS_LAST) begin
            d.sda_oe = 1'b0;
            d.state  = tws_pkg::S_TX_ACK;
          end else begin
            d.shift   = {q.shift[6:0], 1'b1};
            d.sda_oe  = ~q.shift[6];
            d.bit_cnt = q.bit_cnt + 4'h1;
          end
        end
      end
      default: begin
        if (bus_start || bus_stop) begin
          d.flag  = 1'b1;
          d.code  = tws_pkg::CODE_BUS_ERR;
          d.state = tws_pkg::S_IDLE;
        end else if (scl_rise) begin
          d.acked = ~sda_new;
        end else if (scl_fall) begin
          d.flag = 1'b1;
          if (!q.acked) begin
            d.code  = tws_pkg::CODE_DATA_NACK;
            d.state = tws_pkg::S_IDLE;
          end else if (q.last) begin
            d.code  = tws_pkg::CODE_LAST_ACK;
            d.state = tws_pkg::S_IGNORE;
          end else begin
            d.code   = tws_pkg::CODE_DATA_ACK;
            d.scl_oe = 1'b1;
            d.state  = tws_pkg::S_HOLD;
          end
        end
      end
    endcase

    if (!q.enable) begin
      d.state  = tws_pkg::S_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end
    if (!sleep_mode) begin
      d.wake = 1'b0;
    end
    d.irq    = d.flag & d.int_en;
    d.status = d.flag ? {d.code[7:3], 1'b0, d.presc}
                      : {tws_pkg::CODE_NONE[7:3], 1'b0, d.presc};
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q          <= '0;
      q.own_addr <= tws_pkg::OWN_ADDR_RST;
      q.data     <= tws_pkg::DATA_RST;
      q.presc    <= tws_pkg::PRESC_RST;
      q.code     <= tws_pkg::CODE_NONE;
      q.status   <= tws_pkg::CODE_NONE;
    end else begin
      q <= d;
    end
  end

  assign pins.scl_oe_dev  = q.scl_oe;
  assign pins.sda_oe_dev  = q.sda_oe;
  assign pins.scl_out_dev = 1'b0;
  assign pins.sda_out_dev = 1'b0;
  assign rd_own_addr      = q.own_addr;
  assign rd_control       = {q.flag, q.ack_en, q.start_req, q.stop_req,
                             q.wcol, q.enable, 1'b0, q.int_en};
  assign rd_data          = q.data;
  assign rd_status        = q.status;
  assign irq              = q.irq;
  assign wake             = q.wake;

endmodule // tws_slave

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [7:0]  own;
    logic [7:0]  ctl;
    logic [6:0]  addr;
    logic [7:0]  cnt;
    logic        arb;
    logic        slp;
    logic [1:0]  n;
    logic [23:0] code;
    logic [15:0] dat;
    logic        nack;
  } tws_row_t;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic [1:0] reg_sel = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       arb_lost = 1'b0;
  logic       sleep_mode = 1'b0;
  logic       go = 1'b0;
  logic [6:0] slave_addr = 7'h00;
  logic [7:0] byte_count = 8'h00;
  logic [7:0] rd_own_addr, rd_control, rd_data, rd_status, rx_data, ctl_b, sts_b;
  logic       irq, wake, rx_valid, done, addr_nack, busy;
  logic [7:0] rx_log [$];
  tws_row_t   rows [4];
  int         err_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  tws_if      bus ();
  tws_if      bus_b ();

  always #5 sys_clk = ~sys_clk;

  tws_slave u_tws_slave (
    .sys_clk(sys_clk), .reset_n(reset_n), .pins(bus), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .arb_lost(arb_lost), .sleep_mode(sleep_mode),
    .rd_own_addr(rd_own_addr), .rd_control(rd_control), .rd_data(rd_data),
    .rd_status(rd_status), .irq(irq), .wake(wake));
  // Second slave faces a bench driver that breaks the framing
  tws_slave u_tws_slave_b (
    .sys_clk(sys_clk), .reset_n(reset_n), .pins(bus_b), .reg_wr(reg_wr), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .arb_lost(arb_lost), .sleep_mode(sleep_mode), .rd_own_addr(),
    .rd_control(ctl_b), .rd_data(), .rd_status(sts_b), .irq(), .wake());
  tws_host u_tws_host (
    .sys_clk(sys_clk), .reset_n(reset_n), .pins(bus), .go(go), .slave_addr(slave_addr),
    .byte_count(byte_count), .rx_data(rx_data), .rx_valid(rx_valid), .done(done),
    .addr_nack(addr_nack), .busy(busy));
  tws_monitor u_tws_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl(bus.scl), .sda(bus.sda),
    .scl_oe_dev(bus.scl_oe_dev), .sda_oe_dev(bus.sda_oe_dev),
    .scl_out_dev(bus.scl_out_dev), .sda_out_dev(bus.sda_out_dev),
    .scl_oe_host(bus.scl_oe_host), .sda_oe_host(bus.sda_oe_host),
    .scl_out_host(bus.scl_out_host), .sda_out_host(bus.sda_out_host));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wreg(input logic [1:0] sel, input logic [7:0] val);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = val;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // One step of the hand-driven second bus: 1 pulls the line low
  task automatic hold_b(input logic scl_lo, input logic sda_lo);
    bus_b.scl_oe_host = scl_lo;
    bus_b.sda_oe_host = sda_lo;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_on(input logic for_done);
    for (int i = 0; i < 30000; i++) begin
      @(posedge sys_clk);
      #1;
      if (for_done ? done === 1'b1 : rd_control[7] === 1'b1) return;
    end
    check("wait", 8'h00, 8'h01);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      wrap_up();
    end
  end

  always @(posedge sys_clk) if (rx_valid === 1'b1) rx_log.push_back(rx_data);

  initial begin
    tws_row_t   r;
    logic [15:0] pat;
    bus_b.scl_oe_host = 1'b0;
    bus_b.sda_oe_host = 1'b0;
    bus_b.scl_out_host = 1'b0;
    bus_b.sda_out_host = 1'b0;
    rows[0] = '{8'h54, 8'h45, 7'h15, 8'h01, 1'b0, 1'b0, 2'h0, 24'h00_0000, 16'h0000, 1'b1};
    rows[1] = '{8'h54, 8'h05, 7'h2A, 8'h01, 1'b0, 1'b0, 2'h0, 24'h00_0000, 16'h0000, 1'b1};
    rows[2] = '{8'h54, 8'h45, 7'h2A, 8'h02, 1'b1, 1'b1, 2'h2, 24'hB0_B8C0, 16'h3CC3, 1'b0};
    rows[3] = '{8'h54, 8'h45, 7'h2A, 8'h02, 1'b0, 1'b0, 2'h1, 24'hA8_C800, 16'h5A00, 1'b0};
    repeat (12) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    foreach (rows[i]) begin
      r = rows[i];
      wreg(tws_pkg::SEL_OWN_ADDR, r.own);
      check("own addr", rd_own_addr, r.own);
      wreg(tws_pkg::SEL_CONTROL, r.ctl);
      check("control", rd_control, r.ctl);
      arb_lost = r.arb;
      sleep_mode = r.slp;
      rx_log.delete();
      @(posedge sys_clk);
      #1;
      go = 1'b1;
      slave_addr = r.addr;
      byte_count = r.cnt;
      @(posedge sys_clk);
      #1;
      go = 1'b0;
      check("busy", {7'h00, busy}, 8'h01);
      for (int k = 0; k <= r.n && !r.nack; k++) begin
        wait_on(1'b0);
        check("status", rd_status, r.code[23 - 8 * k -: 8]);
        if (k == 0) check("irq", {7'h00, irq}, 8'h01);
        if (k == 0 && r.slp) check("wake hold", {7'h00, wake & ~bus.scl}, 8'h01);
        if (k < r.n) wreg(tws_pkg::SEL_DATA, r.dat[15 - 8 * k -: 8]);
        wreg(tws_pkg::SEL_CONTROL, (k + 1 == r.n) ? 8'h85 : 8'hC5);
      end
      if (!r.nack) check("idle status", rd_status, tws_pkg::CODE_NONE);
      wait_on(1'b1);
      check("idle busy", {7'h00, busy}, 8'h00);
      check("addr nack", {7'h00, addr_nack}, {7'h00, r.nack});
      check("rx count", 8'(rx_log.size()), r.nack ? 8'h00 : r.cnt);
      foreach (rx_log[j]) check("rx byte", rx_log[j], j < r.n ? r.dat[15 - 8 * j -: 8] : 8'hFF);
      arb_lost = 1'b0;
      sleep_mode = 1'b0;
    end
    // Start, two address bits, then a second start inside the address
    pat = 16'hE1DE;
    for (int i = 7; i >= 0; i--) begin
      bus_b.scl_oe_host = ~pat[2 * i + 1];
      bus_b.sda_oe_host = ~pat[2 * i];
      repeat (20) @(posedge sys_clk);
      #1;
    end
    check("error code", sts_b, tws_pkg::CODE_BUS_ERR);
    check("error flag", {7'h00, ctl_b[7]}, 8'h01);
    check("error release", {6'h00, bus_b.scl_oe_dev, bus_b.sda_oe_dev}, 8'h00);
    bus_b.scl_oe_host = 1'b0;
    bus_b.sda_oe_host = 1'b0;
    wreg(tws_pkg::SEL_CONTROL, 8'hD5);
    check("stop cleared", {7'h00, ctl_b[4]}, 8'h00);
    check("error idle", sts_b, tws_pkg::CODE_NONE);
    // General call write on the second bus, first refused, then answered
    for (int g = 0; g < 2; g++) begin
      wreg(tws_pkg::SEL_OWN_ADDR, {7'h2A, g[0]});
      hold_b(1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
        hold_b(1'b1, 1'b1);
        hold_b(1'b0, 1'b1);
      end
      hold_b(1'b1, 1'b1);
      hold_b(1'b1, 1'b0);
      hold_b(1'b0, 1'b0);
      check("gc ack", {7'h00, bus_b.sda_oe_dev}, {7'h00, g[0]});
      hold_b(1'b1, 1'b0);
      check("gc flag", {7'h00, ctl_b[7]}, {7'h00, g[0]});
      check("gc code", sts_b, g[0] ? tws_pkg::CODE_GC_WRITE : tws_pkg::CODE_NONE);
      hold_b(1'b1, 1'b1);
      hold_b(1'b0, 1'b1);
      hold_b(1'b0, 1'b0);
      wreg(tws_pkg::SEL_CONTROL, 8'hC5);
    end
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    check("rst own", rd_own_addr, tws_pkg::OWN_ADDR_RST);
    check("rst control", rd_control, 8'h00);
    check("rst data", rd_data, tws_pkg::DATA_RST);
    check("rst status", rd_status, tws_pkg::CODE_NONE);
    check("rst flags", {4'h0, irq, wake, bus.scl_oe_dev, bus.sda_oe_dev}, 8'h00);
    wreg(tws_pkg::SEL_STATUS, 8'h03);
    check("prescaler", rd_status, 8'hFB);
    wreg(tws_pkg::SEL_DATA, 8'h11);
    check("refused data", rd_data, tws_pkg::DATA_RST);
    check("collision", {7'h00, rd_control[3]}, 8'h01);
    wrap_up();
  end
endmodule // tb_top

// ---- tb/tws_monitor.sv ----
`timescale 1ns/100ps
module tws_monitor (
  input wire logic sys_clk,      // Clock
  input wire logic reset_n,      // Reset
  input wire logic scl,          // Bus clock
  input wire logic sda,          // Bus data
  input wire logic scl_oe_dev,   // Slave pulls scl
  input wire logic sda_oe_dev,   // Slave pulls sda
  input wire logic scl_out_dev,  // Slave level
  input wire logic sda_out_dev,  // Slave level
  input wire logic scl_oe_host,  // Host pulls scl
  input wire logic sda_oe_host,  // Host pulls sda
  input wire logic scl_out_host, // Host level
  input wire logic sda_out_host  // Host level
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Cycles that scl has been high
  logic [15:0] hi_cnt_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !scl) hi_cnt_q <= 16'h0000;
    else if (hi_cnt_q != 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h0001;
  end

  a_dev_out_low: assert property (!scl_out_dev && !sda_out_dev)
    else $error("slave drives a high level");
  a_host_out_low: assert property (!scl_out_host && !sda_out_host)
    else $error("host drives a high level");
  a_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sda_oe_dev))
    else $error("slave data moved while scl high");
  a_dev_stretch_low: assert property ($rose(scl_oe_dev) |-> !$past(scl))
    else $error("slave pulled a high clock low");
  a_stretch_sda_free: assert property ($rose(scl_oe_dev) |-> !sda_oe_dev)
    else $error("slave held sda while starting a stretch");
  a_start_quarter: assert property ($fell(sda) && scl && $past(scl) |-> ##[200:260] !scl)
    else $error("start not followed by clock fall");
  a_no_dev_start: assert property ($fell(sda) && scl && $past(scl) |-> !sda_oe_dev)
    else $error("slave formed a start");
  a_scl_high_min: assert property ($fell(scl) |-> hi_cnt_q >= 16'h0032)
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");

  c_stretch: cover property ($rose(scl_oe_dev));
  c_dev_data: cover property ($rose(sda_oe_dev));
  c_start: cover property ($fell(sda) && scl && $past(scl));
endmodule // tws_monitor
